// ===== rtl/sbc_array.sv
// Storage array with per-lane writes and a registered read word.
`timescale 1ns/1ps
module sbc_array #(
  parameter int ADDR_W = sbc_pkg::SBC_ADDR_W
) (
  // Clock
  input wire logic sys_clk,
  // Write port
  input wire logic wr_en,
  input wire logic [sbc_pkg::SBC_LANES-1:0] wr_lanes,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire sbc_pkg::sbc_word_t wr_word,
  // Read port
  input wire logic rd_en,
  input wire logic [ADDR_W-1:0] rd_addr,
  output sbc_pkg::sbc_word_t rd_word
);
  import sbc_pkg::*;

  localparam int DEPTH = 1 << ADDR_W;

  // ---------------------------------------------------------------------------
  // Lanes
  // ---------------------------------------------------------------------------
  // Each lane owns its own array, so a byte write never touches its neighbours.
  // The array has no reset on purpose: contents survive reset and sleep.
  for (genvar l = 0; l < SBC_LANES; l++)
  begin : g_lane
    logic [SBC_LANE_W:0] lane_mem [DEPTH];
    logic [SBC_LANE_W:0] lane_rd_r;

    always_ff @(posedge sys_clk)
    begin
      if (wr_en && wr_lanes[l])
      begin
        lane_mem[wr_addr] <= {wr_word.parity_bus[l], wr_word.data[l*SBC_LANE_W +: SBC_LANE_W]};
      end
    end

    always_ff @(posedge sys_clk)
    begin
      if (rd_en)
      begin
        lane_rd_r <= lane_mem[rd_addr];
      end
    end

    assign rd_word.parity_bus[l] = lane_rd_r[SBC_LANE_W];
    assign rd_word.data[l*SBC_LANE_W +: SBC_LANE_W] = lane_rd_r[SBC_LANE_W-1:0];
  end

endmodule : sbc_array

// ===== rtl/sbc_burst_counter.sv
// Two-bit wraparound burst counter with linear and interleaved order.
`timescale 1ns/1ps
module sbc_burst_counter (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Control
  input wire logic load,
  input wire logic [sbc_pkg::SBC_BURST_W-1:0] load_val,
  input wire logic step,
  input wire logic order_interleave,
  // Burst address bits
  output logic [sbc_pkg::SBC_BURST_W-1:0] cur_lo,
  output logic [sbc_pkg::SBC_BURST_W-1:0] nxt_lo
);
  import sbc_pkg::*;

  logic [SBC_BURST_W-1:0] start_r;
  logic [SBC_BURST_W-1:0] count_r;

  // ---------------------------------------------------------------------------
  // Order decode
  // ---------------------------------------------------------------------------
  // Interleaved order XORs the step count in, linear order adds it modulo four.
  function automatic logic [SBC_BURST_W-1:0] burst_addr(
    input logic [SBC_BURST_W-1:0] start,
    input logic [SBC_BURST_W-1:0] n,
    input logic interleave
  );
    burst_addr = interleave ? (start ^ n) : SBC_BURST_W'(start + n);
  endfunction : burst_addr

  // The same decode serves the current and the following address.
  assign cur_lo = burst_addr(start_r, count_r, order_interleave);
  assign nxt_lo = burst_addr(start_r, SBC_BURST_W'(count_r + 2'h1), order_interleave);

  // A load restarts the burst at the given pair; the step count wraps by width.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      start_r <= 2'h0;
      count_r <= 2'h0;
    end
    else if (load)
    begin
      start_r <= load_val;
      count_r <= 2'h0;
    end
    else if (step)
    begin
      count_r <= SBC_BURST_W'(count_r + 2'h1);
    end
  end

endmodule : sbc_burst_counter

// ===== rtl/sbc_pkg.sv
// Shared constants, types and states of the synchronous burst cache SRAM.
package sbc_pkg;

  // ---------------------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------------------
  localparam int SBC_ADDR_W = 17;
  localparam int SBC_DATA_W = 32;
  localparam int SBC_LANES = 4;
  localparam int SBC_LANE_W = 8;
  localparam int SBC_BURST_W = 2;

  // ---------------------------------------------------------------------------
  // Timing counts and reset values
  // ---------------------------------------------------------------------------
  // Entering or leaving sleep takes this many clock cycles.
  localparam int SBC_SLEEP_CYC = 2;
  localparam logic [1:0] SBC_SLEEP_CNT_LAST = 2'(SBC_SLEEP_CYC - 1);
  // Synchroniser reset: bit 1 is the order select (pull-up), bit 0 is sleep (pull-down).
  localparam logic [1:0] SBC_SYNC_RST = 2'h2;
  localparam int SBC_SYNC_SLEEP = 0;
  localparam int SBC_SYNC_MODE = 1;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  // One storage word: four parity bits above 32 data bits.
  typedef struct packed {
    logic [SBC_LANES-1:0] parity_bus;
    logic [SBC_DATA_W-1:0] data;
  } sbc_word_t;

  // Chip enables as they appear on the pins.
  typedef struct packed {
    logic select_a_n;
    logic select_b;
    logic select_c_n;
  } sbc_select_t;

  // Write controls as they appear on the pins.
  typedef struct packed {
    logic all_lanes_write_n;
    logic lane_write_enable_n;
    logic [SBC_LANES-1:0] lane_select_n;
  } sbc_write_ctl_t;

  // ---------------------------------------------------------------------------
  // Power states
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    SBC_ST_RUN = 4'h1,
    SBC_ST_ENTER = 4'h2,
    SBC_ST_SLEEP = 4'h4,
    SBC_ST_WAKE = 4'h8
  } sbc_state_t;

endpackage : sbc_pkg

// ===== rtl/sbc_sram.sv
// Top level of the synchronous flow-through burst cache SRAM.
`timescale 1ns/1ps
module sbc_sram #(
  parameter int ADDR_W = sbc_pkg::SBC_ADDR_W
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Address and strobes
  input wire logic [ADDR_W-1:0] addr,
  input wire logic processor_addr_strobe_n,
  input wire logic controller_addr_strobe_n,
  input wire logic burst_step_n,
  // Selects and write controls
  input wire sbc_pkg::sbc_select_t sel_pins,
  input wire sbc_pkg::sbc_write_ctl_t write_ctl,
  // Asynchronous controls
  input wire logic out_enable_n,
  input wire logic sleep_request,
  input wire logic burst_order,
  // Data and parity pins
  input wire sbc_pkg::sbc_word_t bus_in,
  output sbc_pkg::sbc_word_t bus_out,
  output logic bus_oe
);
  import sbc_pkg::*;

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  logic [1:0] sync1_r;
  logic [1:0] sync2_r;
  logic sleep_s;
  logic interleave_s;
  sbc_state_t st_r;
  sbc_state_t st_nxt;
  logic [1:0] pwr_cnt_r;
  logic [1:0] pwr_cnt_nxt;
  logic run;
  logic selected;
  logic proc_seen;
  logic ctrl_seen;
  logic new_access;
  logic deselect;
  logic continue_burst;
  logic wr_req;
  logic [SBC_LANES-1:0] wr_lanes;
  logic wr_fire;
  logic rd_fire;
  logic [ADDR_W-1:0] eff_addr;
  logic [ADDR_W-SBC_BURST_W-1:0] addr_hi_r;
  logic [SBC_BURST_W-1:0] cur_lo;
  logic [SBC_BURST_W-1:0] nxt_lo;
  logic active_r;
  logic write_r;
  logic proc_first_r;

  // ---------------------------------------------------------------------------
  // Synchronisers for the asynchronous level inputs
  // ---------------------------------------------------------------------------
  // Sleep and the order strap change slowly, so a plain two-stage level sync is enough.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_r <= SBC_SYNC_RST;
      sync2_r <= SBC_SYNC_RST;
    end
    else
    begin
      sync1_r <= {burst_order, sleep_request};
      sync2_r <= sync1_r;
    end
  end

  assign sleep_s = sync2_r[SBC_SYNC_SLEEP];
  assign interleave_s = sync2_r[SBC_SYNC_MODE];

  // ---------------------------------------------------------------------------
  // Power state machine
  // ---------------------------------------------------------------------------
  // Each transition through ENTER or WAKE lasts the documented number of cycles.
  always_comb
  begin
    st_nxt = st_r;
    pwr_cnt_nxt = pwr_cnt_r;
    case (st_r)
      SBC_ST_RUN:
      begin
        if (sleep_s)
        begin
          st_nxt = SBC_ST_ENTER;
          pwr_cnt_nxt = 2'h0;
        end
      end
      SBC_ST_ENTER:
      begin
        pwr_cnt_nxt = 2'(pwr_cnt_r + 2'h1);
        if (pwr_cnt_r == SBC_SLEEP_CNT_LAST)
        begin
          st_nxt = SBC_ST_SLEEP;
        end
      end
      SBC_ST_SLEEP:
      begin
        if (!sleep_s)
        begin
          st_nxt = SBC_ST_WAKE;
          pwr_cnt_nxt = 2'h0;
        end
      end
      SBC_ST_WAKE:
      begin
        pwr_cnt_nxt = 2'(pwr_cnt_r + 2'h1);
        if (pwr_cnt_r == SBC_SLEEP_CNT_LAST)
        begin
          st_nxt = SBC_ST_RUN;
        end
      end
      default:
      begin
        st_nxt = SBC_ST_RUN;
        pwr_cnt_nxt = 2'h0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= SBC_ST_RUN;
      pwr_cnt_r <= 2'h0;
    end
    else
    begin
      st_r <= st_nxt;
      pwr_cnt_r <= pwr_cnt_nxt;
    end
  end

  // Outside RUN every other input is ignored.
  assign run = (st_r == SBC_ST_RUN);

  // ---------------------------------------------------------------------------
  // Cycle decode
  // ---------------------------------------------------------------------------
  assign selected = !sel_pins.select_a_n && sel_pins.select_b && !sel_pins.select_c_n;
  // The first enable gates the processor strobe before anything else looks at it.
  assign proc_seen = !processor_addr_strobe_n && !sel_pins.select_a_n;
  // A recognised processor strobe masks the controller strobe.
  assign ctrl_seen = !controller_addr_strobe_n && !proc_seen;
  assign new_access = run && (proc_seen || ctrl_seen) && selected;
  assign deselect = run && (proc_seen || ctrl_seen) && !selected;
  // A burst keeps going on the counter whatever the enables say.
  assign continue_burst = run && !proc_seen && !ctrl_seen && active_r;

  // Global write overrides; otherwise the lane enable qualifies the lane selects.
  always_comb
  begin
    if (!write_ctl.all_lanes_write_n)
    begin
      wr_lanes = 4'hF;
    end
    else if (!write_ctl.lane_write_enable_n)
    begin
      wr_lanes = ~write_ctl.lane_select_n;
    end
    else
    begin
      wr_lanes = 4'h0;
    end
  end

  assign wr_req = |wr_lanes;
  // Processor starts are always reads; controller starts and continuations may write.
  assign wr_fire = wr_req && ((new_access && ctrl_seen) || continue_burst);
  assign rd_fire = !wr_req ? (new_access || continue_burst) : (new_access && proc_seen);

  // ---------------------------------------------------------------------------
  // Effective address
  // ---------------------------------------------------------------------------
  // A new access uses the pins; a continuation steps or repeats the counter.
  always_comb
  begin
    if (new_access)
    begin
      eff_addr = addr;
    end
    else if (!burst_step_n)
    begin
      eff_addr = {addr_hi_r, nxt_lo};
    end
    else
    begin
      eff_addr = {addr_hi_r, cur_lo};
    end
  end

  // Upper bits change only on a recognised, selected strobe.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addr_hi_r <= '0;
    end
    else if (new_access)
    begin
      addr_hi_r <= addr[ADDR_W-1:SBC_BURST_W];
    end
  end

  sbc_burst_counter u_burst (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .load(new_access),
    .load_val(addr[SBC_BURST_W-1:0]),
    .step(continue_burst && !burst_step_n),
    .order_interleave(interleave_s),
    .cur_lo(cur_lo),
    .nxt_lo(nxt_lo)
  );

  // ---------------------------------------------------------------------------
  // Cycle state
  // ---------------------------------------------------------------------------
  // A deselect or a trip into sleep ends the burst; pending accesses are dropped.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      active_r <= 1'b0;
    end
    else if (!run || deselect)
    begin
      active_r <= 1'b0;
    end
    else if (new_access)
    begin
      active_r <= 1'b1;
    end
  end

  // Remembers that the last edge wrote, so the pins stay released.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      write_r <= 1'b0;
    end
    else
    begin
      write_r <= wr_fire;
    end
  end

  // Marks the first edge of a processor-started cycle, used by the strobe priority check.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      proc_first_r <= 1'b0;
    end
    else
    begin
      proc_first_r <= new_access && proc_seen;
    end
  end

  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------
  // Written data is taken straight off the pins at the edge, with no extra stage.
  sbc_array #(
    .ADDR_W(ADDR_W)
  ) u_array (
    .sys_clk(sys_clk),
    .wr_en(wr_fire),
    .wr_lanes(wr_lanes),
    .wr_addr(eff_addr),
    .wr_word(bus_in),
    .rd_en(rd_fire),
    .rd_addr(eff_addr),
    .rd_word(bus_out)
  );

  // ---------------------------------------------------------------------------
  // Pin direction
  // ---------------------------------------------------------------------------
  // Output enable is not sampled, so the pins follow it within the same cycle.
  // Write cycles and sleep override it to keep the host free to drive the bus.
  assign bus_oe = !out_enable_n && active_r && !write_r && run;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  a_load_addr: assert property (@(posedge sys_clk) disable iff (!rst_n)
    new_access |=> (cur_lo == $past(addr[SBC_BURST_W-1:0])) && active_r)
    else $error("burst counter not loaded from address pins");

  a_proc_priority: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (run && selected && !processor_addr_strobe_n && !controller_addr_strobe_n) |=> proc_first_r)
    else $error("controller strobe won over processor strobe");

  a_ce1_gates_proc: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (run && active_r && sel_pins.select_a_n && controller_addr_strobe_n) |=> active_r && $stable(addr_hi_r))
    else $error("processor strobe acted while first enable high");

  a_burst_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (continue_burst && !burst_step_n) |=> (cur_lo == $past(nxt_lo)))
    else $error("burst counter did not advance");

  a_burst_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (continue_burst && burst_step_n) |=> $stable(cur_lo) && $stable(addr_hi_r))
    else $error("burst counter moved without a step");

  a_mode_strap: assert property (@(posedge sys_clk) disable iff (!rst_n)
    burst_order [*3] |-> interleave_s)
    else $error("order select not seen as interleaved");

  a_write_release: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_fire |=> !bus_oe)
    else $error("pins driven after a write");

  a_proc_no_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (new_access && proc_seen) |-> !wr_fire)
    else $error("write taken at first edge of processor cycle");

  a_ctrl_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (new_access && ctrl_seen && wr_req) |-> wr_fire)
    else $error("controller write not taken at its edge");

  a_sleep_entry: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (run && sleep_s) |=> (st_r == SBC_ST_ENTER) [*2] ##1 (st_r == SBC_ST_SLEEP))
    else $error("sleep entry did not take two cycles");

  a_sleep_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !run |-> !wr_fire && !rd_fire && !bus_oe)
    else $error("access while not running");

  a_oe_follows: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bus_oe |-> !out_enable_n && active_r)
    else $error("pins driven with output enable high");

  c_proc_read: cover property (@(posedge sys_clk) disable iff (!rst_n)
    (new_access && proc_seen) ##1 (continue_burst && wr_req));
  c_ctrl_write: cover property (@(posedge sys_clk) disable iff (!rst_n)
    new_access && ctrl_seen && wr_req);
  c_full_burst: cover property (@(posedge sys_clk) disable iff (!rst_n)
    new_access ##1 (continue_burst && !burst_step_n) [*3]);
  c_sleep_cycle: cover property (@(posedge sys_clk) disable iff (!rst_n)
    (st_r == SBC_ST_WAKE) ##2 run);

endmodule : sbc_sram

// ===== test/sbc_host_model.sv
// Host-side partner model: drives the pins and resolves the shared data bus.
`timescale 1ns/1ps
module sbc_host_model #(
  parameter int ADDR_W = 6
) (
  // Clock and device outputs
  input wire logic sys_clk,
  input wire sbc_pkg::sbc_word_t bus_out,
  input wire logic bus_oe,
  // Pins toward the device
  output logic [ADDR_W-1:0] addr,
  output logic processor_addr_strobe_n,
  output logic controller_addr_strobe_n,
  output logic burst_step_n,
  output sbc_pkg::sbc_select_t sel_pins,
  output sbc_pkg::sbc_write_ctl_t write_ctl,
  output logic out_enable_n,
  output logic sleep_request,
  output logic burst_order,
  output sbc_pkg::sbc_word_t bus_in
);
  import sbc_pkg::*;
  sbc_word_t drv_r;
  sbc_word_t last_r;
  logic drv_en_r;
  // ---------------------------------------------------------------------------
  // Bus resolution
  // ---------------------------------------------------------------------------
  // A released bus shows the inverse of its last level, so stale data never passes for good data.
  assign bus_in = bus_oe ? bus_out : (drv_en_r ? drv_r : ~last_r);
  always @(posedge sys_clk)
  begin
    last_r <= bus_in;
  end
  // Idle, deselected pins from time zero.
  initial
  begin
    {addr, drv_r, last_r, drv_en_r, sleep_request} = '0;
    {processor_addr_strobe_n, controller_addr_strobe_n, burst_step_n, out_enable_n, burst_order} = 5'h1f;
    sel_pins = 3'h5;
    write_ctl = 6'h3f;
  end
  // ---------------------------------------------------------------------------
  // Host cycle
  // ---------------------------------------------------------------------------
  // New pin values just after a rising edge; the next edge samples them.
  task automatic put(input logic p_n, input logic c_n, input logic st_n, input sbc_select_t s,
                     input sbc_write_ctl_t w, input logic [ADDR_W-1:0] a, input sbc_word_t d, input logic oe_n);
    @(posedge sys_clk);
    processor_addr_strobe_n <= p_n;
    controller_addr_strobe_n <= c_n;
    burst_step_n <= st_n;
    sel_pins <= s;
    write_ctl <= w;
    addr <= a;
    drv_r <= d;
    drv_en_r <= (w != 6'h3f); // The host drives data only when it asks for a write.
    out_enable_n <= oe_n;
    #1;
  endtask : put
  // Straps change only after a deselect has ended any burst, so a held burst never sees its order flip.
  task automatic straps(input logic o, input logic z);
    put(1'b1, 1'b0, 1'b1, 3'h5, 6'h3f, '0, '0, 1'b1);
    @(posedge sys_clk);
    burst_order <= o;
    sleep_request <= z;
    controller_addr_strobe_n <= 1'b1;
    #1;
  endtask : straps
endmodule : sbc_host_model

// ===== test/sbc_sram_test.sv
// Self-checking testbench for the burst cache SRAM.
`timescale 1ns/1ps
module sbc_sram_test;
  import sbc_pkg::*;
  localparam int AW = 6;
  localparam sbc_select_t ON = 3'h2;
  localparam sbc_select_t OFF = 3'h5;
  localparam sbc_write_ctl_t NW = 6'h3f;
  localparam sbc_write_ctl_t GWR = 6'h1f;
  logic sys_clk;
  logic rst_n;
  logic [AW-1:0] addr;
  logic p_n, c_n, st_n, oe_n, sleep, order, bus_oe;
  sbc_select_t sel;
  sbc_write_ctl_t wc;
  sbc_word_t bus_in, bus_out;
  sbc_word_t exp_mem [0:63];
  int n_errors = 0;
  int checked = 0;
  sbc_host_model #(.ADDR_W(AW)) host (.sys_clk(sys_clk), .bus_out(bus_out), .bus_oe(bus_oe), .addr(addr),
    .processor_addr_strobe_n(p_n), .controller_addr_strobe_n(c_n), .burst_step_n(st_n), .sel_pins(sel),
    .write_ctl(wc), .out_enable_n(oe_n), .sleep_request(sleep), .burst_order(order), .bus_in(bus_in));
  sbc_sram #(.ADDR_W(AW)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr), .processor_addr_strobe_n(p_n),
    .controller_addr_strobe_n(c_n), .burst_step_n(st_n), .sel_pins(sel), .write_ctl(wc), .out_enable_n(oe_n),
    .sleep_request(sleep), .burst_order(order), .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe));
  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  function automatic sbc_word_t pat(input int a, input int k);
    return {4'(a + k), 32'h5a00_0000 + 32'(a << 8) + 32'(k) * 32'h0101_0101};
  endfunction : pat
  // Expected storage follows the lane pairing; a global write overrides the lanes.
  function automatic void upd(input int a, input sbc_write_ctl_t w, input sbc_word_t d);
    for (int n = 0; n < 4; n++)
    begin
      if (!w.all_lanes_write_n || (!w.lane_write_enable_n && !w.lane_select_n[n]))
      begin
        exp_mem[a].data[8*n +: 8] = d.data[8*n +: 8];
        exp_mem[a].parity_bus[n] = d.parity_bus[n];
      end
    end
  endfunction : upd
  task automatic chk(input string name, input logic [35:0] seen, input logic [35:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // Controller read, then a hold cycle that shows the word read at the start edge.
  task automatic rd(input int a, input string name);
    host.put(1'b1, 1'b0, 1'b1, ON, NW, AW'(a), '0, 1'b0);
    host.put(1'b1, 1'b1, 1'b1, OFF, NW, '0, '0, 1'b0);
    chk(name, bus_out, exp_mem[a]);
  endtask : rd
  task automatic end_sim();
    if (n_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  // Back-to-back global writes with output enable wrongly held low.
  task automatic t_fill();
    for (int a = 0; a < 64; a++)
    begin
      host.put(1'b1, 1'b0, 1'b1, ON, GWR, AW'(a), pat(a, 0), 1'b0);
      exp_mem[a] = pat(a, 0);
      if (a > 0)
        chk("oe_after_write", 36'(bus_oe), 36'h0);
    end
    rd(63, "fill_read");
  endtask : t_fill
  // Bursts of both orders from every start, both strobes; deselected ignored strobes continue.
  task automatic t_burst();
    logic [1:0] lo;
    for (int o = 0; o < 2; o++)
    begin
      host.straps(1'(o), 1'b0);
      repeat (3) host.put(1'b1, 1'b1, 1'b1, OFF, NW, '0, '0, 1'b1);
      for (int s = 0; s < 8; s++)
      begin
        host.put(s >= 4, s < 4, 1'b1, ON, NW, AW'(16 + s % 4), '0, 1'b0);
        for (int j = 0; j < 5; j++)
        begin
          host.put(1'b0, 1'b1, j > 2, 3'h7, NW, '0, '0, 1'b0);
          lo = o ? 2'(s % 4) ^ 2'(j > 3 ? 3 : j) : 2'(s % 4 + (j > 3 ? 3 : j));
          chk("burst_word", bus_out, exp_mem[16 + lo]);
          chk("burst_oe", 36'(bus_oe), 36'h1);
        end
        host.put(1'b1, 1'b1, 1'b1, OFF, NW, '0, '0, 1'b1);
        chk("oe_high", 36'(bus_oe), 36'h0);
      end
    end
  endtask : t_burst
  // Lane masks, lane selects without the lane write enable, and the enable with no lane selected.
  task automatic t_lanes();
    logic [3:0] m [8] = '{4'h0, 4'he, 4'hd, 4'hb, 4'h7, 4'ha, 4'h5, 4'hf};
    sbc_write_ctl_t w;
    for (int i = 0; i < 8; i++)
    begin
      w = {1'b1, i == 0, m[i]};
      host.put(1'b1, 1'b0, 1'b1, ON, w, AW'(40), pat(40, i + 1), 1'b1);
      upd(40, w, pat(40, i + 1));
      rd(40, "lane_write");
    end
  endtask : t_lanes
  // Both strobes with a global write read only; a processor start writes at the next edge.
  task automatic t_strobes();
    host.put(1'b0, 1'b0, 1'b1, ON, GWR, AW'(50), pat(50, 9), 1'b1);
    host.put(1'b1, 1'b1, 1'b1, OFF, NW, '0, '0, 1'b1);
    rd(50, "both_strobes");
    host.put(1'b0, 1'b1, 1'b1, ON, NW, AW'(50), '0, 1'b1);
    host.put(1'b1, 1'b1, 1'b1, ON, GWR, '0, pat(50, 9), 1'b1);
    exp_mem[50] = pat(50, 9);
    rd(50, "proc_write");
  endtask : t_strobes
  // Each missing chip enable blocks a controller write.
  task automatic t_select();
    sbc_select_t s [3] = '{3'h0, 3'h3, 3'h6};
    for (int i = 0; i < 3; i++)
    begin
      host.put(1'b1, 1'b0, 1'b1, s[i], GWR, AW'(60), pat(60, 5), 1'b1);
      rd(60, "deselect");
    end
  endtask : t_select
  // Accesses during sleep are ignored and contents survive it.
  task automatic t_sleep();
    host.straps(1'b1, 1'b1);
    repeat (8) host.put(1'b1, 1'b1, 1'b1, OFF, NW, '0, '0, 1'b0);
    chk("sleep_oe", 36'(bus_oe), 36'h0);
    host.put(1'b1, 1'b0, 1'b1, ON, GWR, AW'(61), pat(61, 3), 1'b1);
    host.put(1'b1, 1'b0, 1'b1, ON, NW, AW'(61), '0, 1'b0);
    host.put(1'b1, 1'b1, 1'b1, OFF, NW, '0, '0, 1'b0);
    chk("sleep_read_oe", 36'(bus_oe), 36'h0);
    host.straps(1'b1, 1'b0);
    repeat (8) host.put(1'b1, 1'b1, 1'b1, OFF, NW, '0, '0, 1'b1);
    rd(61, "sleep_keep");
  endtask : t_sleep
  // ---------------------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_fill();
    t_burst();
    t_lanes();
    t_strobes();
    t_select();
    t_sleep();
    end_sim();
  end
  // The whole run needs well under a thousand cycles, so this only cuts a hang.
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    n_errors++;
    end_sim();
  end
endmodule : sbc_sram_test
